// *** logic/bcr_recorder.sv ***
// bus-cycle trace recorder: samples the target bus each bus cycle into trace memory
// assumes target pins asynchronous, run and stop-condition inputs on mclk_in
`timescale 1ns/10ps
`default_nettype none
`include "bcr_consts.svh"
module bcr_recorder (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // target bus pins
  input wire logic tgt_bclk_in,
  input wire logic [23:0] tgt_addr_in,
  input wire logic [2:0] tgt_bank_in,
  input wire logic [15:0] tgt_data_in,
  input wire logic tgt_bus16_in,
  input wire logic upper_byte_lane_enable_in,
  input wire logic [2:0] bus_unit_transaction_kind_in,
  input wire logic [1:0] tgt_dir_in,
  input wire logic cycle_valid_strobe_n_in,
  // emulator control
  input wire logic prog_run_in,
  input wire logic stop_cond_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // status
  output logic trace_active_out,
  output logic trace_halted_out
);
  typedef struct packed {
    bcr_pkg::bcr_state_t st;
    logic run_prev;
    logic bclk_prev;
    logic ctl_en;
    logic ctl_free;
    logic ctl_ext;
    logic [`BCR_DLY_W-1:0] delay_cfg;
    logic [`BCR_PTR_W-1:0] wr_ptr;
    logic [`BCR_CNT_W-1:0] count;
    logic [`BCR_PTR_W-1:0] stop_ptr;
    logic delay_used;
    logic [`BCR_DLY_W-1:0] delay_left;
    logic [`BCR_DLY_W-1:0] delay_taken;
    logic wrapped;
    logic [`BCR_PTR_W-1:0] index_sel;
    logic [31:0] rdata;
  } bcr_top_st_t;

  bcr_top_st_t r_reg, r_next;
  bcr_mem_if mif ();
  logic [`BCR_SYNC_W-1:0] pins_s;
  logic bclk_s;
  bcr_pkg::bcr_rec_t rec_now;
  logic bus_cyc;
  logic run_rise;
  logic capturing;
  logic [`BCR_PTR_W-1:0] anchor;

  bcr_sync #(.W(`BCR_SYNC_W)) u_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .d_in({tgt_bclk_in, tgt_addr_in, tgt_bank_in, tgt_data_in, tgt_bus16_in, upper_byte_lane_enable_in,
           bus_unit_transaction_kind_in, tgt_dir_in, cycle_valid_strobe_n_in}),
    .q_out(pins_s)
  );

  bcr_trace_mem u_mem (
    .mclk_in(mclk_in),
    .mp(mif.store)
  );

  // banked address form for extended bank mode
  function automatic logic [31:0] rec_addr(input logic ext, input logic [2:0] bank, input logic [23:0] a);
    if (ext && bank != `BCR_BANK_NONE) rec_addr = {1'b1, bank, 4'h0, a};
    else rec_addr = {8'h00, a};
  endfunction : rec_addr

  assign bclk_s = pins_s[51];

  // record built from synchronised pins
  always_comb begin
    rec_now = '0;
    rec_now.addr = rec_addr(r_reg.ctl_ext, pins_s[26:24], pins_s[50:27]);
    rec_now.data = pins_s[23:8];
    rec_now.bus16 = pins_s[7];
    rec_now.upper_byte_lane_enable = pins_s[6];
    rec_now.bus_unit_transaction_kind = pins_s[5:3];
    rec_now.dir = pins_s[2:1];
    rec_now.cycle_valid_strobe_n = pins_s[0];
  end

  assign bus_cyc = bclk_s & ~r_reg.bclk_prev;
  assign run_rise = prog_run_in & ~r_reg.run_prev;
  assign anchor = r_reg.delay_used ? r_reg.stop_ptr : r_reg.wr_ptr - `BCR_PTR_W'(1);

  always_comb begin
    r_next = r_reg;
    r_next.bclk_prev = bclk_s;
    r_next.run_prev = prog_run_in;
    mif.wr_en = 1'b0;
    mif.wr_addr = r_reg.wr_ptr;
    mif.wr_data = rec_now;
    mif.rd_addr = anchor + r_reg.index_sel;
    capturing = 1'b0;

    // program start opens a fresh trace in the same cycle
    if (run_rise && r_reg.ctl_en) begin
      r_next.st = bcr_pkg::bcr_st_capture;
      r_next.wr_ptr = '0;
      r_next.count = '0;
      r_next.delay_used = 1'b0;
      r_next.delay_taken = '0;
      r_next.wrapped = 1'b0;
    end
    capturing = prog_run_in && (r_next.st == bcr_pkg::bcr_st_capture || r_next.st == bcr_pkg::bcr_st_delay);

    if (!prog_run_in && (r_reg.st == bcr_pkg::bcr_st_capture || r_reg.st == bcr_pkg::bcr_st_delay))
      r_next.st = bcr_pkg::bcr_st_halted;

    if (capturing && bus_cyc) begin
      mif.wr_en = 1'b1;
      mif.wr_addr = r_next.wr_ptr;
      r_next.wr_ptr = r_next.wr_ptr + `BCR_PTR_W'(1);
      if (r_next.count == `BCR_DEPTH) r_next.wrapped = 1'b1;
      else r_next.count = r_next.count + `BCR_CNT_W'(1);
      if (r_next.st == bcr_pkg::bcr_st_delay) begin
        r_next.delay_taken = r_reg.delay_taken + `BCR_DLY_W'(1);
        r_next.delay_left = r_reg.delay_left - `BCR_DLY_W'(1);
        if (r_reg.delay_left == `BCR_DLY_W'(1)) r_next.st = bcr_pkg::bcr_st_halted;
      end else if (stop_cond_in && !r_reg.ctl_free) begin
        r_next.stop_ptr = mif.wr_addr;
        r_next.delay_used = (r_reg.delay_cfg != '0);
        r_next.delay_left = r_reg.delay_cfg;
        if (r_reg.delay_cfg == '0) r_next.st = bcr_pkg::bcr_st_halted;
        else r_next.st = bcr_pkg::bcr_st_delay;
      end
    end

    // register writes
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `BCR_OFF_CTRL: begin
          r_next.ctl_en = reg_wdata_in[`BCR_CTRL_EN];
          r_next.ctl_free = reg_wdata_in[`BCR_CTRL_FREE];
          r_next.ctl_ext = reg_wdata_in[`BCR_CTRL_EXT];
        end
        `BCR_OFF_DELAY: r_next.delay_cfg = reg_wdata_in[`BCR_DLY_W-1:0];
        `BCR_OFF_INDEX: r_next.index_sel = reg_wdata_in[`BCR_PTR_W-1:0];
        default: ;
      endcase
    end

    // register reads, answered in the next cycle
    r_next.rdata = '0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `BCR_OFF_CTRL: r_next.rdata = {29'h0, r_reg.ctl_ext, r_reg.ctl_free, r_reg.ctl_en};
        `BCR_OFF_DELAY: r_next.rdata = {16'h0, r_reg.delay_cfg};
        `BCR_OFF_STATUS: r_next.rdata = {28'h0, r_reg.wrapped, r_reg.delay_used, r_reg.st};
        `BCR_OFF_COUNT: r_next.rdata = {9'h0, r_reg.count};
        `BCR_OFF_LAST: r_next.rdata = r_reg.delay_used ? {16'h0, r_reg.delay_taken} : 32'h0;
        `BCR_OFF_INDEX: r_next.rdata = {{10{r_reg.index_sel[`BCR_PTR_W-1]}}, r_reg.index_sel};
        `BCR_OFF_RADDR: r_next.rdata = mif.rd_data.addr;
        `BCR_OFF_RINFO: r_next.rdata = {8'h0, mif.rd_data.cycle_valid_strobe_n, mif.rd_data.dir,
                                        mif.rd_data.bus_unit_transaction_kind,
                                        mif.rd_data.upper_byte_lane_enable, mif.rd_data.bus16, mif.rd_data.data};
        default: r_next.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r_reg <= '0;
      r_reg.ctl_en <= `BCR_CTRL_EN_RST;
      r_reg.delay_cfg <= `BCR_DELAY_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata_out = r_reg.rdata;
  assign trace_active_out = (r_reg.st == bcr_pkg::bcr_st_capture) || (r_reg.st == bcr_pkg::bcr_st_delay);
  assign trace_halted_out = (r_reg.st == bcr_pkg::bcr_st_halted);

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_stop_hit;
    r_reg.st == bcr_pkg::bcr_st_capture && prog_run_in && bus_cyc && stop_cond_in && !r_reg.ctl_free;
  endsequence

  sequence s_last_delay_cycle;
    r_reg.st == bcr_pkg::bcr_st_delay && prog_run_in && bus_cyc && r_reg.delay_left == 16'h0001;
  endsequence

  a_cycle_written: assert property (capturing && bus_cyc |-> mif.wr_en)
    else $error("bus cycle during capture not written");

  a_depth_bound: assert property (r_reg.count <= `BCR_DEPTH)
    else $error("record count beyond trace depth");

  a_wrap_keeps_full: assert property (r_reg.count == `BCR_DEPTH && mif.wr_en
                                      |=> r_reg.count == `BCR_DEPTH && r_reg.wrapped)
    else $error("full trace did not wrap");

  a_halt_on_stop: assert property (trace_active_out && !prog_run_in && !run_rise |=> trace_halted_out)
    else $error("program stop did not halt capture");

  a_default_fill: assert property (r_reg.st == bcr_pkg::bcr_st_capture && prog_run_in && !stop_cond_in
                                   && !run_rise |=> r_reg.st == bcr_pkg::bcr_st_capture)
    else $error("default capture ended without a stop");

  a_start_same_cycle: assert property (run_rise && r_reg.ctl_en && bus_cyc
                                       |-> mif.wr_en && mif.wr_addr == 22'h000000)
    else $error("capture did not start with program start");

  a_newest_zero: assert property (trace_halted_out && !r_reg.delay_used && r_reg.index_sel == 22'h000000
                                  |-> mif.rd_addr == r_reg.wr_ptr - 22'h000001)
    else $error("newest record not at index zero");

  a_stop_to_delay: assert property (s_stop_hit ##0 (r_reg.delay_cfg != 16'h0000)
                                    |=> r_reg.st == bcr_pkg::bcr_st_delay && r_reg.delay_used
                                        && r_reg.stop_ptr == $past(r_reg.wr_ptr)
                                        && r_reg.delay_left == $past(r_reg.delay_cfg))
    else $error("stop condition record not anchored");

  a_delay_exact: assert property (s_last_delay_cycle |=> trace_halted_out
                                  && r_reg.delay_taken == r_reg.delay_cfg)
    else $error("delay capture length wrong");

  a_bank_bits: assert property (mif.wr_en && r_reg.ctl_ext && pins_s[26:24] != 3'h7
                                |-> mif.wr_data.addr[31] && mif.wr_data.addr[30:28] == pins_s[26:24])
    else $error("bank bits not recorded");

  a_record_fields: assert property (mif.wr_en |-> mif.wr_data[23:0] == pins_s[23:0])
    else $error("record fields differ from bus pins");

  a_read_one_cycle: assert property (reg_rd_in && reg_addr_in == `BCR_OFF_COUNT
                                     |=> reg_rdata_out == {9'h0, $past(r_reg.count)})
    else $error("count read not returned next cycle");
endmodule : bcr_recorder
`default_nettype wire

// *** logic/bcr_sync.sv ***
// two-flop synchroniser for the sampled target bus pins
// assumes inputs asynchronous to mclk_in
`timescale 1ns/10ps
`default_nettype none
module bcr_sync #(parameter int W = 1) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bcr_sync_st_t;
  bcr_sync_st_t r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    r_next.s1 = d_in;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) r_reg <= '0;
    else r_reg <= r_next;
  end

  assign q_out = r_reg.s2;
endmodule : bcr_sync
`default_nettype wire

// *** logic/bcr_trace_mem.sv ***
// dual-port trace record store, one write and one registered read a cycle
// assumes control end drives the port on mclk_in
`timescale 1ns/10ps
`default_nettype none
`include "bcr_consts.svh"
module bcr_trace_mem (
  // clock
  input wire logic mclk_in,
  // memory port
  bcr_mem_if.store mp
);
  bcr_pkg::bcr_rec_t mem [0:`BCR_DEPTH-1];

  // no reset: contents are only meaningful below the record count
  always_ff @(posedge mclk_in) begin
    if (mp.wr_en) mem[mp.wr_addr] <= mp.wr_data;
    mp.rd_data <= mem[mp.rd_addr];
  end
endmodule : bcr_trace_mem
`default_nettype wire

// *** shared/bcr_consts.svh ***
// constants for the bus-cycle trace recorder: offsets, fields, resets, sizes
// assumes inclusion by bare name from any recorder source file
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH

// trace memory geometry: 4 Mi records
`define BCR_PTR_W 22
`define BCR_DEPTH 23'h400000
`define BCR_CNT_W 23
`define BCR_DLY_W 16
// target pins gathered in one synchroniser word
`define BCR_SYNC_W 52
`define BCR_BANK_NONE 3'h7

// register offsets (byte addresses)
`define BCR_OFF_CTRL 8'h00
`define BCR_OFF_DELAY 8'h04
`define BCR_OFF_STATUS 8'h08
`define BCR_OFF_COUNT 8'h0C
`define BCR_OFF_LAST 8'h10
`define BCR_OFF_INDEX 8'h14
`define BCR_OFF_RADDR 8'h18
`define BCR_OFF_RINFO 8'h1C

// control fields and reset values
`define BCR_CTRL_EN 0
`define BCR_CTRL_FREE 1
`define BCR_CTRL_EXT 2
`define BCR_CTRL_EN_RST 1'h1
`define BCR_DELAY_RST 16'h0000

`endif

// *** shared/bcr_mem_if.sv ***
// trace memory port bundle between recorder control and storage
// assumes both ends run on the recorder clock
`timescale 1ns/10ps
`default_nettype none
`include "bcr_consts.svh"
interface bcr_mem_if;
  logic wr_en;
  logic [`BCR_PTR_W-1:0] wr_addr;
  bcr_pkg::bcr_rec_t wr_data;
  logic [`BCR_PTR_W-1:0] rd_addr;
  bcr_pkg::bcr_rec_t rd_data;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport store (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface
`default_nettype wire

// *** shared/bcr_pkg.sv ***
// types of the bus-cycle trace recorder: record layout, kinds, states
// assumes nothing of its surroundings
package bcr_pkg;

  typedef enum logic [2:0] {
    bcr_k_no_change,
    bcr_k_non_cpu,
    bcr_k_int_ack,
    bcr_k_opcode_fetch_byte,
    bcr_k_cpu_data_byte_access,
    bcr_k_opcode_fetch_word,
    bcr_k_cpu_data_word_access
  } bcr_kind_t;

  typedef enum logic [1:0] {bcr_d_none, bcr_d_read, bcr_d_write} bcr_dir_t;

  typedef enum logic [1:0] {bcr_st_idle, bcr_st_capture, bcr_st_delay, bcr_st_halted} bcr_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
    logic bus16;
    logic upper_byte_lane_enable;
    logic [2:0] bus_unit_transaction_kind;
    logic [1:0] dir;
    logic cycle_valid_strobe_n;
  } bcr_rec_t;

endpackage : bcr_pkg

// *** tb/bcr_tgt_model.sv ***
// target bus model: drives one bus cycle at a time onto the recorder pins
// assumes the bench calls cycle() from the recorder clock domain
`timescale 1ns/10ps
`default_nettype none
module bcr_tgt_model (
  // clock
  input wire logic mclk_in,
  // target bus pins
  output var logic tgt_bclk_out,
  output var logic [23:0] tgt_addr_out,
  output var logic [2:0] tgt_bank_out,
  output var logic [15:0] tgt_data_out,
  output var logic tgt_bus16_out,
  output var logic upper_byte_lane_enable_out,
  output var logic [2:0] bus_unit_transaction_kind_out,
  output var logic [1:0] tgt_dir_out,
  output var logic cycle_valid_strobe_n_out
);
  initial begin
    tgt_bclk_out = 1'h0;
    {tgt_addr_out, tgt_bank_out, tgt_data_out, tgt_bus16_out, upper_byte_lane_enable_out,
      bus_unit_transaction_kind_out, tgt_dir_out, cycle_valid_strobe_n_out} = 51'h1;
  end

  // pins stable well around the clock rise, so the synced word is whole
  task automatic cycle(input logic [50:0] p);
    @(posedge mclk_in);
    {tgt_addr_out, tgt_bank_out, tgt_data_out, tgt_bus16_out, upper_byte_lane_enable_out,
      bus_unit_transaction_kind_out, tgt_dir_out, cycle_valid_strobe_n_out} <= p;
    repeat (3) @(posedge mclk_in);
    tgt_bclk_out <= 1'h1;
    repeat (4) @(posedge mclk_in);
    tgt_bclk_out <= 1'h0;
    // released data lines: show the inverse, never a stale value
    tgt_data_out <= ~tgt_data_out;
    cycle_valid_strobe_n_out <= 1'h1;
    repeat (2) @(posedge mclk_in);
  endtask : cycle
endmodule : bcr_tgt_model
`default_nettype wire

// *** tb/test_bus_cycle_trace_recorder.sv ***
// self-checking bench for the bus-cycle trace recorder
// assumes the target model drives the pins; the bench drives control and registers
`timescale 1ns/10ps
`default_nettype none
`include "bcr_consts.svh"
module test_bus_cycle_trace_recorder;
  typedef struct packed {
    logic [50:0] pins;
    logic [31:0] ea;
  } bcr_row_t;
  logic mclk_in = 1'h0;
  logic rst_n_in = 1'h0;
  wire logic tgt_bclk_in;
  wire logic [23:0] tgt_addr_in;
  wire logic [2:0] tgt_bank_in;
  wire logic [15:0] tgt_data_in;
  wire logic tgt_bus16_in;
  wire logic upper_byte_lane_enable_in;
  wire logic [2:0] bus_unit_transaction_kind_in;
  wire logic [1:0] tgt_dir_in;
  wire logic cycle_valid_strobe_n_in;
  logic prog_run_in = 1'h0;
  logic stop_cond_in = 1'h0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h00000000;
  logic reg_wr_in = 1'h0;
  logic reg_rd_in = 1'h0;
  logic [31:0] reg_rdata_out;
  logic trace_active_out;
  logic trace_halted_out;
  int miscompares = 0;
  int comparisons = 0;
  bcr_row_t rows [8];
  logic [31:0] d;

  always #2.5 mclk_in = ~mclk_in;

  bcr_tgt_model tgt (.mclk_in(mclk_in), .tgt_bclk_out(tgt_bclk_in), .tgt_addr_out(tgt_addr_in),
    .tgt_bank_out(tgt_bank_in), .tgt_data_out(tgt_data_in), .tgt_bus16_out(tgt_bus16_in),
    .upper_byte_lane_enable_out(upper_byte_lane_enable_in),
    .bus_unit_transaction_kind_out(bus_unit_transaction_kind_in), .tgt_dir_out(tgt_dir_in),
    .cycle_valid_strobe_n_out(cycle_valid_strobe_n_in));

  bcr_recorder dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .tgt_bclk_in(tgt_bclk_in),
    .tgt_addr_in(tgt_addr_in), .tgt_bank_in(tgt_bank_in), .tgt_data_in(tgt_data_in),
    .tgt_bus16_in(tgt_bus16_in), .upper_byte_lane_enable_in(upper_byte_lane_enable_in),
    .bus_unit_transaction_kind_in(bus_unit_transaction_kind_in), .tgt_dir_in(tgt_dir_in),
    .cycle_valid_strobe_n_in(cycle_valid_strobe_n_in), .prog_run_in(prog_run_in),
    .stop_cond_in(stop_cond_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .trace_active_out(trace_active_out), .trace_halted_out(trace_halted_out));

  function automatic logic [31:0] info(input logic [50:0] p);
    return {8'h00, p[0], p[2:1], p[5:3], p[6], p[7], p[23:8]};
  endfunction : info

  task automatic stop_test();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_in);
    reg_wr_in <= 1'h1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge mclk_in);
    reg_wr_in <= 1'h0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input string nm, input logic [31:0] exp);
    @(posedge mclk_in);
    reg_rd_in <= 1'h1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'h0;
    #1 d = reg_rdata_out;
    chk(nm, d, exp);
  endtask : rchk

  // one stored record: index, then address and info words
  task automatic rec(input logic [31:0] idx, input logic [50:0] p, input logic [31:0] ea);
    wr(`BCR_OFF_INDEX, idx);
    repeat (2) @(posedge mclk_in);
    rchk(`BCR_OFF_RADDR, "raddr", ea);
    rchk(`BCR_OFF_RINFO, "rinfo", info(p));
  endtask : rec

  task automatic go(input logic [50:0] p, input logic s);
    @(posedge mclk_in);
    stop_cond_in <= s;
    tgt.cycle(p);
    stop_cond_in <= 1'h0;
  endtask : go

  initial begin
    #200000;
    miscompares++;
    stop_test();
  end

  initial begin
    rows[0] = '{{24'h012345, 3'h0, 16'hA5A5, 1'h1, 1'h1, 3'h0, 2'h0, 1'h1}, 32'h80012345};
    rows[1] = '{{24'h0FFFFE, 3'h6, 16'h1234, 1'h1, 1'h0, 3'h1, 2'h1, 1'h0}, 32'hE00FFFFE};
    rows[2] = '{{24'hFFFFFF, 3'h7, 16'h5AC3, 1'h0, 1'h1, 3'h2, 2'h0, 1'h0}, 32'h00FFFFFF};
    rows[3] = '{{24'h000001, 3'h3, 16'h00FF, 1'h0, 1'h0, 3'h3, 2'h1, 1'h0}, 32'hB0000001};
    rows[4] = '{{24'h800000, 3'h1, 16'hFF00, 1'h0, 1'h1, 3'h4, 2'h2, 1'h0}, 32'h90800000};
    rows[5] = '{{24'h123456, 3'h2, 16'h8001, 1'h1, 1'h1, 3'h5, 2'h1, 1'h0}, 32'hA0123456};
    rows[6] = '{{24'hABCDEF, 3'h4, 16'h7FFE, 1'h1, 1'h0, 3'h6, 2'h2, 1'h0}, 32'hC0ABCDEF};
    rows[7] = '{{24'h055AA0, 3'h5, 16'hC33C, 1'h1, 1'h1, 3'h4, 2'h2, 1'h0}, 32'hD0055AA0};
    repeat (2) @(posedge mclk_in);
    #1 chk("rdata_rst", reg_rdata_out, 32'h00000000);
    chk("halted_rst", {31'h0, trace_halted_out}, 32'h00000000);
    @(posedge mclk_in);
    rst_n_in <= 1'h1;
    rchk(`BCR_OFF_CTRL, "ctrl_rst", 32'h00000001);
    rchk(`BCR_OFF_DELAY, "delay_rst", 32'h00000000);
    rchk(`BCR_OFF_STATUS, "status_rst", 32'h00000000);
    rchk(8'h20, "unmapped", 32'h00000000);
    // fill mode, banked addresses, all kinds and directions
    wr(`BCR_OFF_CTRL, 32'h00000005);
    @(posedge mclk_in) prog_run_in <= 1'h1;
    for (int i = 0; i < 8; i++) go(rows[i].pins, i == 7);
    repeat (3) @(posedge mclk_in);
    chk("halted", {31'h0, trace_halted_out}, 32'h00000001);
    @(posedge mclk_in) prog_run_in <= 1'h0;
    rchk(`BCR_OFF_COUNT, "count", 32'h00000008);
    rchk(`BCR_OFF_STATUS, "status", 32'h00000003);
    rchk(`BCR_OFF_LAST, "last", 32'h00000000);
    wr(`BCR_OFF_INDEX, 32'hFFFFFFF9);
    rchk(`BCR_OFF_INDEX, "index", 32'hFFFFFFF9);
    for (int i = 0; i < 8; i++) rec(32'(i - 7), rows[i].pins, rows[i].ea);
    // delay of two after the stop condition
    wr(`BCR_OFF_CTRL, 32'h00000001);
    wr(`BCR_OFF_DELAY, 32'h00000002);
    @(posedge mclk_in) prog_run_in <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      go(rows[i].pins, i == 2);
      if (i == 3) chk("active_delay", {31'h0, trace_active_out}, 32'h00000001);
    end
    @(posedge mclk_in) prog_run_in <= 1'h0;
    rchk(`BCR_OFF_COUNT, "count_dly", 32'h00000005);
    rchk(`BCR_OFF_LAST, "last_dly", 32'h00000002);
    rchk(`BCR_OFF_STATUS, "status_dly", 32'h00000007);
    rec(32'h00000000, rows[2].pins, {8'h00, rows[2].pins[50:27]});
    rec(32'h00000002, rows[4].pins, {8'h00, rows[4].pins[50:27]});
    rec(32'hFFFFFFFE, rows[0].pins, {8'h00, rows[0].pins[50:27]});
    // free mode: stop condition ignored, follows program run only
    wr(`BCR_OFF_CTRL, 32'h00000003);
    wr(`BCR_OFF_DELAY, 32'h00000000);
    @(posedge mclk_in) prog_run_in <= 1'h1;
    go(rows[0].pins, 1'h1);
    go(rows[1].pins, 1'h0);
    chk("active_free", {31'h0, trace_active_out}, 32'h00000001);
    @(posedge mclk_in) prog_run_in <= 1'h0;
    repeat (2) @(posedge mclk_in);
    chk("halted_free", {31'h0, trace_halted_out}, 32'h00000001);
    go(rows[2].pins, 1'h0);
    rchk(`BCR_OFF_COUNT, "count_free", 32'h00000002);
    wr(`BCR_OFF_COUNT, 32'h00000000);
    rchk(`BCR_OFF_COUNT, "count_ro", 32'h00000002);
    rec(32'h00000000, rows[1].pins, {8'h00, rows[1].pins[50:27]});
    rec(32'hFFFFFFFF, rows[0].pins, {8'h00, rows[0].pins[50:27]});
    // reset in mid capture, program still running
    @(posedge mclk_in) prog_run_in <= 1'h1;
    go(rows[3].pins, 1'h0);
    @(posedge mclk_in) rst_n_in <= 1'h0;
    @(posedge mclk_in);
    #1 chk("active_mid_rst", {31'h0, trace_active_out}, 32'h00000000);
    @(posedge mclk_in) rst_n_in <= 1'h1;
    rchk(`BCR_OFF_CTRL, "ctrl_mid_rst", 32'h00000001);
    rchk(`BCR_OFF_COUNT, "count_mid_rst", 32'h00000000);
    chk("active_after_rst", {31'h0, trace_active_out}, 32'h00000001);
    @(posedge mclk_in) prog_run_in <= 1'h0;
    stop_test();
  end
endmodule : test_bus_cycle_trace_recorder
`default_nettype wire
